// ### logic/tmr_pkg.sv
// timer 1 package: register map, field layout and types
`default_nettype none
package tmr_pkg;
  localparam int unsigned  ADDR_W     = 12;
  localparam logic [9:0]   IDX_CLKSEL = 10'h0D8;
  localparam logic [9:0]   IDX_MODE   = 10'h0DC;
  localparam logic [9:0]   IDX_COUNT  = 10'h0DD;
  localparam logic [9:0]   IDX_RELOAD = 10'h0DE;
  localparam logic [9:0]   IDX_STATUS = 10'h0E0;
  localparam logic [7:0]   RST_BYTE   = 8'h00;
  localparam int unsigned  FAST_BIT   = 3;
  localparam int unsigned  OVF_BIT    = 0;
  localparam int unsigned  IRQEN_BIT  = 1;
  localparam int unsigned  PINIRQ_BIT = 2;
  localparam logic [7:0]   MASK_256   = 8'hFF;
  localparam logic [7:0]   MASK_64    = 8'h3F;
  localparam logic [7:0]   MASK_32    = 8'h1F;
  localparam logic [7:0]   MASK_16    = 8'h0F;
  localparam logic [7:0]   PSC_FULL   = 8'hFF;
  localparam logic [3:0]   PSC_BITS   = 4'h8;
  localparam logic [1:0]   RESP_OKAY  = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;

  // field order matches the mode register, bit 7 down to bit 0
  typedef struct packed {
    logic       run_en;
    logic [2:0] prescale_sel;
    logic       ext_clock_sel;
    logic       autoreload_en;
    logic       tone_out_en;
    logic       pwm_out_en;
  } tmr_mode_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } tmr_wr_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } tmr_rd_t;
endpackage : tmr_pkg
`default_nettype wire

// ### logic/tmr_timer1.sv
// timer 1: reload counter, prescaler, event input, tone/pwm pin, axi-lite
// Functional notes
// [R1] 8-bit up counter; overflow sets sticky flag until software clears it
// [R2] each overflow loads the counter from the active reload value; code does so only with auto-reload or pwm on, else it wraps to 0x00
// [R3] without pwm, or in event mode, overflow boundary is 256 counts
// [R4] in pwm mode reload/tone bits pick boundary 256, 64, 32 or 16
// [R5] reload writes land in a holding buffer, moved to active at overflow
// [R6] software loads count and reload alike before run; later only reload
// [R7] pwm mode forces auto-reload; the reload bit then picks the boundary
// [R8] software computes load value as boundary minus interval times clock
// [R9] event mode counts falling edges of the event input pin
// [R10] event mode overflow occurs when count goes from 0xFF to 0x00
// [R11] event mode suppresses the pin's level-change wake-up
// [R12] event mode disables the pin interrupt and holds its flag at 0
// [R13] tone output toggles on each overflow, half the overflow rate
// [R14] tone enable takes the pin from gpio; clearing returns it to gpio
// [R15] overflow flag and interrupt request still work with tone active
// [R16] software keeps pwm output off while using the tone output
// [R17] count clock is instruction clock /2..256 or fast clock /1..128
// [R18] counter advances only while run enable is set, else holds
// [R19] prescale codes 0..7 pick /256 down to /2, or /128 down to /1
// [R20] pwm level goes high at overflow, low when count equals reload
// [R21] event mode ignores prescale and fast clock selection
// [R22] event pin passes a two-flop synchroniser before edge detection
// [R23] tone toggle clears on reset and holds while the timer is stopped
//
// The AXI4-Lite register port was left to the implementer.
`default_nettype none
module tmr_timer1 (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [tmr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [tmr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      instr_cycle_tick,
  input  wire logic                      high_osc_tick,
  input  wire logic                      event_input_pin,
  input  wire logic                      gpio_out,
  input  wire logic                      gpio_oe,
  output logic                           tone_pwm_pin_o,
  output logic                           tone_pwm_pin_oe,
  output logic                           tmr1_irq_req,
  output logic                           event_wake_req,
  output logic                           pin_ext_irq
);
  tmr_pkg::tmr_wr_t wst_q, wst_d;
  tmr_pkg::tmr_rd_t rst_q, rst_d;
  logic [tmr_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0]  wbyte_q, wbyte_d;
  logic        wlane_q, wlane_d;
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_do;
  logic [9:0]  widx;
  logic        wr_hit;

  tmr_pkg::tmr_mode_t mode_q, mode_d;
  logic        fast_q, fast_d, irqen_q, irqen_d;
  logic [7:0]  count_q, count_d, hold_q, hold_d, active_q, active_d;
  logic [7:0]  psc_q, psc_d;
  logic        flag_q, flag_d, pinflag_q, pinflag_d;
  logic        tone_q, tone_d, pwm_lvl_q, pwm_lvl_d;
  logic        ev_s1_q, ev_s2_q, ev_prev_q;
  logic        pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
  logic        irq_q, irq_d, wake_q, wake_d;
  logic [7:0]  mask, psc_full;
  logic [3:0]  psc_bits;
  logic        ev_fall, src_tick, cnt_tick, ovf, reload_on;
  logic        wr_mode, wr_count, wr_reload, wr_status, wr_clk;

  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  assign tone_pwm_pin_o  = pin_o_q;
  assign tone_pwm_pin_oe = pin_oe_q;
  assign tmr1_irq_req    = irq_q;
  assign event_wake_req  = wake_q;
  assign pin_ext_irq     = pinflag_q;

  // word index decode; misaligned or unknown addresses answer slverr
  function automatic logic known(input logic [tmr_pkg::ADDR_W-1:0] a);
    logic [9:0] i;
    i = a[tmr_pkg::ADDR_W-1:2];
    known = (a[1:0] == 2'h0) &&
            (i == tmr_pkg::IDX_CLKSEL || i == tmr_pkg::IDX_MODE ||
             i == tmr_pkg::IDX_COUNT || i == tmr_pkg::IDX_RELOAD ||
             i == tmr_pkg::IDX_STATUS);
  endfunction : known

  function automatic logic [7:0] rd_byte(input logic [9:0] i);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      tmr_pkg::IDX_MODE:   v = mode_q;
      tmr_pkg::IDX_CLKSEL: v[tmr_pkg::FAST_BIT] = fast_q;
      tmr_pkg::IDX_COUNT:  v = count_q;
      tmr_pkg::IDX_STATUS: begin
        v[tmr_pkg::OVF_BIT]    = flag_q;
        v[tmr_pkg::IRQEN_BIT]  = irqen_q;
        v[tmr_pkg::PINIRQ_BIT] = pinflag_q;
      end
      default:             v = 8'h00;
    endcase
    rd_byte = v;
  endfunction : rd_byte

  assign widx   = awaddr_q[tmr_pkg::ADDR_W-1:2];
  assign wr_hit = known(awaddr_q);

  // address and data are taken in either order; response after both
  always_comb begin
    wst_d = wst_q;
    awaddr_d = awaddr_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    wr_do = 1'b0;
    unique case (wst_q)
      tmr_pkg::WR_IDLE: begin
        if (s_axi_awvalid && awready_q) begin
          awaddr_d = s_axi_awaddr;
          aw_got_d = 1'b1;
          awready_d = 1'b0;
        end
        if (s_axi_wvalid && wready_q) begin
          wbyte_d = s_axi_wdata[7:0];
          wlane_d = s_axi_wstrb[0];
          w_got_d = 1'b1;
          wready_d = 1'b0;
        end
        if (aw_got_q && w_got_q) begin
          wr_do = wr_hit && wlane_q;
          bresp_d = wr_hit ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
          bvalid_d = 1'b1;
          aw_got_d = 1'b0;
          w_got_d = 1'b0;
          wst_d = tmr_pkg::WR_RESP;
        end
      end
      tmr_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          awready_d = 1'b1;
          wready_d = 1'b1;
          wst_d = tmr_pkg::WR_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    rst_d = rst_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    unique case (rst_q)
      tmr_pkg::RD_IDLE: begin
        if (s_axi_arvalid) begin
          rdata_d = {24'h000000, rd_byte(s_axi_araddr[tmr_pkg::ADDR_W-1:2])};
          rresp_d = known(s_axi_araddr) ? tmr_pkg::RESP_OKAY
                                        : tmr_pkg::RESP_SLVERR;
          if (!known(s_axi_araddr)) rdata_d = 32'h00000000;
          rvalid_d = 1'b1;
          arready_d = 1'b0;
          rst_d = tmr_pkg::RD_DATA;
        end
      end
      tmr_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          rvalid_d = 1'b0;
          arready_d = 1'b1;
          rst_d = tmr_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= tmr_pkg::WR_IDLE;
      rst_q <= tmr_pkg::RD_IDLE;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
    end else begin
      wst_q <= wst_d;
      rst_q <= rst_d;
      awaddr_q <= awaddr_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign wr_mode   = wr_do && widx == tmr_pkg::IDX_MODE;
  assign wr_clk    = wr_do && widx == tmr_pkg::IDX_CLKSEL;
  assign wr_count  = wr_do && widx == tmr_pkg::IDX_COUNT;
  assign wr_reload = wr_do && widx == tmr_pkg::IDX_RELOAD;
  assign wr_status = wr_do && widx == tmr_pkg::IDX_STATUS;

  always_comb begin
    ev_fall = ev_prev_q && !ev_s2_q; // R9 R22
    // prescaler width: fast clock /2^(7-sel), instruction clock one more
    psc_bits = {1'b0, ~mode_q.prescale_sel} + {3'h0, !fast_q}; // R17 R19
    psc_full = tmr_pkg::PSC_FULL >> (tmr_pkg::PSC_BITS - psc_bits);
    src_tick = fast_q ? high_osc_tick : instr_cycle_tick; // R17
    cnt_tick = mode_q.run_en && (mode_q.ext_clock_sel ? ev_fall // R18 R21
               : src_tick && ((psc_q & psc_full) == psc_full));
    mask = tmr_pkg::MASK_256; // R3
    if (mode_q.pwm_out_en && !mode_q.ext_clock_sel) begin
      unique case ({mode_q.autoreload_en, mode_q.tone_out_en}) // R4
        2'b00:   mask = tmr_pkg::MASK_256;
        2'b01:   mask = tmr_pkg::MASK_64;
        2'b10:   mask = tmr_pkg::MASK_32;
        2'b11:   mask = tmr_pkg::MASK_16;
      endcase
    end
    ovf = cnt_tick && ((count_q & mask) == mask); // R10
    reload_on = mode_q.autoreload_en || mode_q.pwm_out_en; // R7
  end

  always_comb begin
    mode_d = wr_mode ? tmr_pkg::tmr_mode_t'(wbyte_q) : mode_q;
    fast_d = wr_clk ? wbyte_q[tmr_pkg::FAST_BIT] : fast_q;
    irqen_d = wr_status ? wbyte_q[tmr_pkg::IRQEN_BIT] : irqen_q;
    psc_d = (mode_q.run_en && !mode_q.ext_clock_sel && src_tick)
            ? psc_q + 8'h01 : psc_q;
    if (!mode_q.run_en) psc_d = 8'h00;
    // a software count write wins over the timer in the same cycle
    count_d = count_q; // R18
    if (wr_count) count_d = wbyte_q;
    else if (ovf && reload_on) count_d = active_q; // R2 R7
    else if (cnt_tick) count_d = count_q + 8'h01; // R1 R9
    hold_d = wr_reload ? wbyte_q : hold_q; // R5
    // stopped timer takes the holding value so the first reload is right
    active_d = (ovf || !mode_q.run_en) ? hold_q : active_q; // R5
    // set wins over clear; writing 0 to the flag clears it
    flag_d = ovf || (flag_q && // R1 R15
             !(wr_status && !wbyte_q[tmr_pkg::OVF_BIT]));
    pinflag_d = !mode_q.ext_clock_sel && (ev_fall || (pinflag_q && // R12
                !(wr_status && !wbyte_q[tmr_pkg::PINIRQ_BIT])));
    tone_d = ovf ? !tone_q : tone_q; // R13 R23
    pwm_lvl_d = pwm_lvl_q;
    if (ovf) pwm_lvl_d = 1'b1; // R20
    else if (mode_q.run_en && mode_q.pwm_out_en &&
             ((count_q & mask) == (active_q & mask))) pwm_lvl_d = 1'b0; // R20
    // pwm has priority on the shared pin, then tone; gpio owns it otherwise
    pin_o_d = mode_q.pwm_out_en ? pwm_lvl_q
            : mode_q.tone_out_en ? tone_q : gpio_out; // R14 R16
    pin_oe_d = (mode_q.pwm_out_en || mode_q.tone_out_en) || gpio_oe; // R14
    irq_d = flag_q && irqen_q; // R15
    wake_d = !mode_q.ext_clock_sel && (ev_s2_q != ev_prev_q); // R11
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= tmr_pkg::tmr_mode_t'(tmr_pkg::RST_BYTE);
      fast_q <= 1'b0;
      irqen_q <= 1'b0;
      count_q <= tmr_pkg::RST_BYTE;
      hold_q <= tmr_pkg::RST_BYTE;
      active_q <= tmr_pkg::RST_BYTE;
      psc_q <= 8'h00;
      flag_q <= 1'b0;
      pinflag_q <= 1'b0;
      tone_q <= 1'b0; // R23
      pwm_lvl_q <= 1'b1;
      ev_s1_q <= 1'b1;
      ev_s2_q <= 1'b1;
      ev_prev_q <= 1'b1;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      fast_q <= fast_d;
      irqen_q <= irqen_d;
      count_q <= count_d;
      hold_q <= hold_d;
      active_q <= active_d;
      psc_q <= psc_d;
      flag_q <= flag_d;
      pinflag_q <= pinflag_d;
      tone_q <= tone_d;
      pwm_lvl_q <= pwm_lvl_d;
      ev_s1_q <= event_input_pin; // R22
      ev_s2_q <= ev_s1_q; // R22
      ev_prev_q <= ev_s2_q;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
      irq_q <= irq_d;
      wake_q <= wake_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ovf_flag;
    ovf |=> flag_q;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) // R1
    else $error("overflow did not set flag");
  property p_reload;
    ovf && reload_on && !wr_count |=> count_q == $past(active_q);
  endproperty
  a_reload: assert property (p_reload) // R2
    else $error("counter not reloaded at overflow");
  property p_bound_full;
    (mode_q.ext_clock_sel || !mode_q.pwm_out_en) |-> mask == 8'hFF;
  endproperty
  a_bound_full: assert property (p_bound_full) // R3
    else $error("boundary not 256 outside pwm");
  property p_bound_16;
    mode_q.pwm_out_en && !mode_q.ext_clock_sel && mode_q.autoreload_en &&
      mode_q.tone_out_en |-> mask == tmr_pkg::MASK_16;
  endproperty
  a_bound_16: assert property (p_bound_16) // R4
    else $error("pwm boundary not 16");
  property p_hold;
    mode_q.run_en && !ovf |=> active_q == $past(active_q);
  endproperty
  a_hold: assert property (p_hold) // R5
    else $error("active reload changed without overflow");
  property p_evt_ovf;
    mode_q.run_en && mode_q.ext_clock_sel && ev_fall && count_q == 8'hFF
      |-> ovf;
  endproperty
  a_evt_ovf: assert property (p_evt_ovf) // R10
    else $error("event overflow missed");
  property p_no_wake;
    mode_q.ext_clock_sel ##1 mode_q.ext_clock_sel |-> !wake_q;
  endproperty
  a_no_wake: assert property (p_no_wake) // R11
    else $error("wake request in event mode");
  property p_pin_flag;
    mode_q.ext_clock_sel |=> !pinflag_q;
  endproperty
  a_pin_flag: assert property (p_pin_flag) // R12
    else $error("pin flag set in event mode");
  property p_tone;
    ovf |=> tone_q != $past(tone_q);
  endproperty
  a_tone: assert property (p_tone) // R13
    else $error("tone did not toggle");
  property p_tone_pin;
    !mode_q.pwm_out_en && mode_q.tone_out_en
      |=> pin_o_q == $past(tone_q) && pin_oe_q;
  endproperty
  a_tone_pin: assert property (p_tone_pin) // R14
    else $error("pin not carrying tone");
  property p_stop;
    !mode_q.run_en && !wr_count |=> count_q == $past(count_q);
  endproperty
  a_stop: assert property (p_stop) // R18
    else $error("counter moved while stopped");
  sequence s_sync;
    ##2 ev_s2_q == $past(event_input_pin, 2);
  endsequence
  property p_sync;
    1'b1 |-> s_sync;
  endproperty
  a_sync: assert property (p_sync) // R22
    else $error("synchroniser latency wrong");
endmodule : tmr_timer1
`default_nettype wire

// ### tb/tmr_partner.sv
// timer 1 far side: event pin source and tone/pwm pin monitor
`default_nettype none
module tmr_partner (
  input  wire logic aclk,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output var logic  event_pin,
  output var int    period
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cyc;
  int   last_rise;
  logic prev_q;
  initial begin
    event_pin = 1'h1; // pin idles high on its pull-up
    cyc = 0;
    last_rise = 0;
    period = 0;
    prev_q = 1'h0;
  end
  // one falling edge per pulse; wide enough for the pin synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge aclk);
      event_pin <= 1'h0;
      repeat (4) @(posedge aclk);
      event_pin <= 1'h1;
      repeat (4) @(posedge aclk);
    end
  endtask : pulse
  // spacing of rising edges on the driven pin, in clock cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev_q <= pin_o & pin_oe;
    if ((pin_o & pin_oe) && !prev_q) begin
      last_rise <= cyc;
      period <= cyc - last_rise;
    end
  end
endmodule : tmr_partner
`default_nettype wire

// ### tb/tb_tmr_timer1.sv
// timer 1 testbench: register bus, prescaler, event, tone and pwm
`default_nettype none
module tb_tmr_timer1;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] CNT = tmr_pkg::IDX_COUNT;
  localparam logic [9:0] RLD = tmr_pkg::IDX_RELOAD;
  localparam logic [9:0] MOD = tmr_pkg::IDX_MODE;
  localparam logic [9:0] STS = tmr_pkg::IDX_STATUS;
  localparam logic [9:0] CKS = tmr_pkg::IDX_CLKSEL;
  localparam logic [1:0] OK  = tmr_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = tmr_pkg::RESP_SLVERR;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [tmr_pkg::ADDR_W-1:0] awaddr = '0;
  logic [tmr_pkg::ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic icyc = 1'h0, hosc = 1'h0, gout = 1'h0, goe = 1'h0;
  logic ev_mode = 1'h0, wake_seen = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic pin_o, pin_oe, irq, wake, pirq, ev_pin;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, v, v2;
  int period, n_fail = 0, n_compared = 0;
  always #5 aclk = ~aclk;
  tmr_timer1 tmr_timer1_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .instr_cycle_tick(icyc), .high_osc_tick(hosc),
    .event_input_pin(ev_pin), .gpio_out(gout), .gpio_oe(goe),
    .tone_pwm_pin_o(pin_o), .tone_pwm_pin_oe(pin_oe),
    .tmr1_irq_req(irq), .event_wake_req(wake), .pin_ext_irq(pirq));
  tmr_partner tmr_partner_i (.aclk(aclk), .pin_o(pin_o),
    .pin_oe(pin_oe), .event_pin(ev_pin), .period(period));
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // both address and data offered together, each released when taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    // bready stays up between writes; raising it again is harmless
    do @(posedge aclk); while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er}, "write response");
  endtask : wr
  task automatic rd(input logic [9:0] idx, output logic [31:0] d,
                    input logic [1:0] er);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er}, "read response");
  endtask : rd
  task automatic rdc(input logic [9:0] idx, input logic [7:0] e,
                     input string what);
    logic [31:0] d;
    rd(idx, d, OK);
    chk(d, {24'h0, e}, what);
  endtask : rdc
  // pin interrupt and wake-up must stay quiet while counting events
  always @(posedge aclk) begin
    if (wake) wake_seen <= 1'h1;
    if (ev_mode && (wake || pirq)) begin
      n_fail++;
      $display("MISMATCH at %0t: pin event leaked in event mode", $time);
    end
  end
  initial begin
    #300us;
    n_fail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    int div, lo, hi;
    logic [2:0] sel;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdc(CNT, 8'h00, "count reset");
    rdc(MOD, 8'h00, "mode reset");
    rdc(STS, 8'h00, "status reset");
    wr(RLD, 8'h5A, OK);
    rdc(RLD, 8'h00, "reload is write-only");
    rd(10'h0F0, v, ERR);
    wr(10'h0F0, 8'h11, ERR);
    $display("registers test done");
    icyc <= 1'h1;
    hosc <= 1'h1;
    // instruction clock /2../16, then fast clock /1 and /2
    for (int i = 0; i < 6; i++) begin
      sel = (i < 4) ? 3'(7 - i) : 3'(11 - i);
      div = (i < 4) ? (2 << i) : (1 << (i - 4));
      wr(CKS, (i < 4) ? 8'h00 : 8'h08, OK);
      wr(CNT, 8'h00, OK);
      wr(RLD, 8'h00, OK);
      wr(MOD, {1'h1, sel, 4'h0}, OK);
      repeat (128) @(posedge aclk);
      wr(MOD, {1'h0, sel, 4'h0}, OK);
      rd(CNT, v, OK);
      lo = 133 / div - (6 / div + 1);
      hi = 133 / div + (6 / div + 1);
      n_compared++;
      if (int'(v) < lo || int'(v) > hi) begin
        n_fail++;
        $display("MISMATCH at %0t: divider %0d count %0d", $time, div, v);
      end
      repeat (20) @(posedge aclk);
      rd(CNT, v2, OK);
      chk(v2, v, "stopped count holds");
    end
    $display("prescaler test done");
    wr(MOD, 8'h00, OK);
    tmr_partner_i.pulse(1);
    rdc(STS, 8'h04, "pin flag outside event mode");
    chk({31'h0, wake_seen}, 32'h1, "wake outside event mode");
    wr(STS, 8'h02, OK);
    wr(CNT, 8'hFE, OK);
    wr(RLD, 8'hFE, OK);
    wr(MOD, 8'hFC, OK);
    ev_mode <= 1'h1;
    wake_seen <= 1'h0;
    tmr_partner_i.pulse(1);
    rdc(CNT, 8'hFF, "one event counted");
    rdc(STS, 8'h02, "no overflow yet");
    wr(RLD, 8'h10, OK);
    tmr_partner_i.pulse(1);
    rdc(CNT, 8'hFE, "old reload after overflow");
    rdc(STS, 8'h03, "overflow flag set");
    chk({31'h0, irq}, 32'h1, "interrupt request");
    tmr_partner_i.pulse(2);
    rdc(CNT, 8'h10, "new reload after next overflow");
    wr(STS, 8'h02, OK);
    rdc(STS, 8'h02, "flag cleared by software");
    chk({31'h0, irq}, 32'h0, "interrupt request dropped");
    wr(MOD, 8'h00, OK);
    ev_mode <= 1'h0;
    chk({31'h0, wake_seen}, 32'h0, "no wake in event mode");
    $display("event test done");
    gout <= 1'h1;
    goe <= 1'h1;
    wr(CKS, 8'h08, OK);
    wr(CNT, 8'hF0, OK);
    wr(RLD, 8'hF0, OK);
    wr(MOD, 8'hF4, OK);
    chk({30'h0, pin_o, pin_oe}, 32'h3, "pin follows port");
    wr(MOD, 8'hF6, OK);
    repeat (100) @(posedge aclk);
    chk(period, 32, "tone period");
    gout <= 1'h0;
    wr(MOD, 8'hF4, OK);
    repeat (2) @(posedge aclk);
    chk({30'h0, pin_o, pin_oe}, 32'h1, "pin back to port");
    rdc(STS, 8'h03, "flag set with tone active");
    $display("tone test done");
    // pwm boundaries 256/64/32/16; reload only forced in pwm mode
    wr(MOD, 8'h00, OK);
    wr(CNT, 8'h00, OK);
    wr(RLD, 8'h08, OK);
    for (int m = 0; m < 4; m++) begin
      div = 256 >> (m == 0 ? 0 : m + 1);
      wr(MOD, {4'hF, 1'h0, 1'(m >> 1), 1'(m), 1'h1}, OK);
      repeat (2 * div + 20) @(posedge aclk);
      chk(period, div - 8, "pwm period");
    end
    $display("pwm test done");
    finish_test();
  end
endmodule : tb_tmr_timer1
`default_nettype wire
